// ==== design/adcs_pkg.sv ====
// Shared constants for the converter sequencer
package adcs_pkg;
	// Result and edge counter widths, result FIFO depth
	localparam int RES_W = 10;
	localparam int CNT_W = 5;
	localparam int FIFO_DEPTH = 16;
	// Converter clock edge counts, from the start edge of a conversion
	localparam logic [4:0] NORM_SH_CNT = 5'h01;
	localparam logic [4:0] NORM_LAST = 5'h0C;
	localparam logic [4:0] FIRST_SH_CNT = 5'h0D;
	localparam logic [4:0] FIRST_LAST = 5'h18;
	localparam logic [4:0] AUTO_SH_CNT = 5'h01;
	localparam logic [4:0] AUTO_LAST = 5'h0D;
	localparam logic [4:0] CNT_ZERO = 5'h00;
	// Trigger source code that chains on completion
	localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
	// Left-adjust padding
	localparam logic [5:0] PAD_ZERO = 6'h00;
	// Reset values
	localparam logic [3:0] CHAN_RESET = 4'h0;
	localparam logic [1:0] REF_RESET = 2'h0;
	localparam logic [9:0] RESULT_RESET = 10'h000;

	typedef enum logic [1:0] {
		ADCS_IDLE = 2'b00,
		ADCS_WAIT = 2'b01,
		ADCS_CONV = 2'b11
	} adcs_state_e;

	// Division ratio for each prescaler select code
	function automatic logic [7:0] adcs_div_ratio(input logic [2:0] sel);
		case (sel)
			3'h0: adcs_div_ratio = 8'h02;
			3'h1: adcs_div_ratio = 8'h02;
			3'h2: adcs_div_ratio = 8'h04;
			3'h3: adcs_div_ratio = 8'h08;
			3'h4: adcs_div_ratio = 8'h10;
			3'h5: adcs_div_ratio = 8'h20;
			3'h6: adcs_div_ratio = 8'h40;
			default: adcs_div_ratio = 8'h80;
		endcase
	endfunction : adcs_div_ratio
endpackage : adcs_pkg

// ==== design/adcs_fifo.sv ====
// Result FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module adcs_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Fill side
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic push, pop;

	assign in_ready = (count != FULL);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and occupancy update
	always_comb begin
		next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
		next_count = count;
		if (push && !pop) begin
			next_count = (AW+1)'(count + 1'b1);
		end else if (pop && !push) begin
			next_count = (AW+1)'(count - 1'b1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// Storage write
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end
endmodule : adcs_fifo
`default_nettype wire

// ==== design/adcs_prescaler.sv ====
// Converter clock prescaler producing rise and fall pulses
`timescale 1ns/10ps
`default_nettype none
module adcs_prescaler (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Control
	input wire logic run,
	input wire logic restart,
	input wire logic [7:0] ratio,
	// Converter clock edges
	output logic rise,
	output logic fall
);
	logic [7:0] cnt, next_cnt;
	logic next_rise, next_fall;
	logic [7:0] top, half;

	assign top = ratio - 8'h01;
	assign half = (ratio >> 1) - 8'h01;

	// Divider held at zero while stopped
	always_comb begin
		next_rise = 1'b0;
		next_fall = 1'b0;
		if (!run || restart) begin
			next_cnt = 8'h00;
		end else if (cnt >= top) begin // Wraps at once after a ratio drop
			next_cnt = 8'h00;
			next_rise = 1'b1;
		end else begin
			next_cnt = cnt + 8'h01;
			next_fall = (cnt == half);
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cnt <= 8'h00;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			cnt <= next_cnt;
			rise <= next_rise;
			fall <= next_fall;
		end
	end
endmodule : adcs_prescaler
`default_nettype wire

// ==== design/adcs_sequencer.sv ====
// Conversion sequencer: start logic, timing, selection buffer, results
`timescale 1ns/10ps
`default_nettype none
// Operation
// RULE1: Start write with power reduction clear begins one conversion; cleared at end.
// RULE2: Channel change during conversion applies only after it completes.
// RULE3: Auto-trigger enable starts conversions from the selected trigger source.
// RULE4: Rising trigger edge restarts the prescaler and starts a conversion.
// RULE5: Trigger still high at completion, or edges while converting, start nothing.
// RULE6: Done flag sets regardless of interrupt enables; trigger flag needs clearing.
// RULE7: Done-flag source chains conversions; first one needs the start bit.
// RULE8: Start write works under auto-trigger; start bit reads one while converting.
// RULE9: Prescaler runs while enabled, held reset while disabled.
// RULE10: Software picks a prescaler giving a suitable converter clock.
// RULE11: A written start begins at the next converter clock rise.
// RULE12: Normal conversion takes 13 cycles, first after enable takes 25.
// RULE13: Sample at 1.5 cycles normally, 13.5 cycles on the first.
// RULE14: Completion writes result, sets done flag, clears start bit if single.
// RULE15: Auto-trigger samples two cycles after trigger; conversion lasts 13.5.
// RULE16: Free running keeps start bit set and restarts on each completion.
// RULE17: Channel and reference go through a buffer, locked during conversion.
// RULE18: Buffer copying resumes in the last cycle before completion.
// RULE19: Software waits one converter cycle after start before new selection.
// RULE20: Software changes selection only at safe moments.
// RULE21: Free-run channel change affects only the conversion after the next.
// RULE22: Low-byte read blocks result updates until high byte read.
// RULE23: Selections take effect only while the converter is enabled.
// RULE24: Result right adjusted, or left adjusted when left adjust is set.
// RULE25: Prescaler ratios and trigger sources are configurable constants.
// RULE26: Interrupt asserts on flag and enable; writing one clears the flag.
module adcs_sequencer (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Software control
	input wire logic converter_enable,
	input wire logic converter_power_reduction,
	input wire logic start_write,
	input wire logic auto_trigger_enable,
	input wire logic [2:0] trigger_source_select,
	input wire logic [2:0] prescaler_select,
	input wire logic left_adjust_result,
	// Selection buffer write
	input wire logic selection_write,
	input wire logic [3:0] channel_select_wdata,
	input wire logic [1:0] reference_select_wdata,
	// Flag, interrupt and result access
	input wire logic done_flag_clear,
	input wire logic done_int_enable,
	input wire logic result_low_read,
	input wire logic result_high_read,
	// Trigger pins, sources 1 to 7
	input wire logic [6:0] trigger_pins,
	// Analog core result
	input wire logic [adcs_pkg::RES_W-1:0] analog_result,
	// Status to software
	output logic conversion_start_bit,
	output logic conversion_done_flag,
	output logic done_irq,
	output logic [7:0] result_low_byte,
	output logic [7:0] result_high_byte,
	// Analog core control
	output logic conv_active,
	output logic sample_hold,
	output logic [3:0] channel_select,
	output logic [1:0] reference_select
);
	adcs_pkg::adcs_state_e state, next_state;
	logic [adcs_pkg::CNT_W-1:0] cnt, next_cnt;
	logic first, next_first, auto_mode, next_auto, en_prev;
	logic next_sh, done_evt, pre_restart, pre_rise, pre_fall;
	logic [6:0] trig_s1, trig_s2;
	logic [7:0] trig_all;
	logic trig_level, trig_prev, trig_edge, free_sel, can_start, last, copy_en;
	logic [3:0] chan_buf, next_chan_buf, next_chan;
	logic [1:0] ref_buf, next_ref_buf, next_ref;
	logic next_flag, next_irq, lock, next_lock;
	logic [adcs_pkg::RES_W-1:0] raw, next_raw, fifo_data;
	logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [15:0] next_res;

	// Final edge count of the running conversion
	function automatic logic [4:0] conv_last(input logic is_first, input logic is_auto);
		if (is_first) begin
			conv_last = adcs_pkg::FIRST_LAST;
		end else if (is_auto) begin
			conv_last = adcs_pkg::AUTO_LAST;
		end else begin
			conv_last = adcs_pkg::NORM_LAST;
		end
	endfunction : conv_last

	// Right or left adjusted result word
	function automatic logic [15:0] fmt_result(input logic [9:0] r, input logic left);
		fmt_result = left ? {r, adcs_pkg::PAD_ZERO} : {adcs_pkg::PAD_ZERO, r};
	endfunction : fmt_result

	// Converter clock, held reset while disabled
	adcs_prescaler u_prescaler (
		.core_clk(core_clk),
		.rst(rst),
		.run(converter_enable), // [RULE9]
		.restart(pre_restart),
		.ratio(adcs_pkg::adcs_div_ratio(prescaler_select)), // [RULE25]
		.rise(pre_rise),
		.fall(pre_fall)
	);

	// Trigger pin synchroniser and edge register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			trig_s1 <= 7'h00;
			trig_s2 <= 7'h00;
			trig_prev <= 1'b0;
			en_prev <= 1'b0;
		end else begin
			trig_s1 <= trigger_pins;
			trig_s2 <= trig_s1;
			trig_prev <= trig_level;
			en_prev <= converter_enable;
		end
	end

	// Trigger selection and start qualification
	assign trig_all = {trig_s2, 1'b0};
	assign trig_level = trig_all[trigger_source_select]; // [RULE3] [RULE25]
	assign trig_edge = trig_level && !trig_prev; // [RULE4]
	assign free_sel = (trigger_source_select == adcs_pkg::TRIG_FREE_RUN);
	assign can_start = converter_enable && !converter_power_reduction && fifo_in_ready;
	assign last = (state == adcs_pkg::ADCS_CONV) && (cnt >= conv_last(first, auto_mode));
	assign copy_en = (state != adcs_pkg::ADCS_CONV) || last; // [RULE17] [RULE18]

	// Conversion state machine
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_first = first;
		next_auto = auto_mode;
		next_sh = 1'b0;
		done_evt = 1'b0;
		pre_restart = 1'b0;
		case (state)
			adcs_pkg::ADCS_IDLE: begin
				// Edges are only seen while idle, so busy-time edges are dropped
				if (can_start && auto_trigger_enable && !free_sel && trig_edge) begin
					next_state = adcs_pkg::ADCS_CONV; // [RULE4] [RULE5]
					next_cnt = adcs_pkg::CNT_ZERO;
					next_auto = 1'b1;
					pre_restart = 1'b1;
				end else if (can_start && start_write) begin
					next_state = adcs_pkg::ADCS_WAIT; // [RULE1] [RULE8]
					next_auto = 1'b0;
				end
			end
			adcs_pkg::ADCS_WAIT: begin
				if (pre_rise) begin
					next_state = adcs_pkg::ADCS_CONV; // [RULE11]
					next_cnt = adcs_pkg::CNT_ZERO;
				end
			end
			adcs_pkg::ADCS_CONV: begin
				if (pre_rise) begin
					next_cnt = adcs_pkg::CNT_W'(cnt + 1'b1);
				end
				if (first) begin
					next_sh = pre_fall && (cnt == adcs_pkg::FIRST_SH_CNT); // [RULE13]
					done_evt = pre_rise && (cnt == adcs_pkg::FIRST_LAST); // [RULE12]
				end else if (auto_mode) begin
					next_sh = pre_rise && (cnt == adcs_pkg::AUTO_SH_CNT); // [RULE15]
					done_evt = pre_fall && (cnt == adcs_pkg::AUTO_LAST); // [RULE15]
				end else begin
					next_sh = pre_fall && (cnt == adcs_pkg::NORM_SH_CNT); // [RULE13]
					done_evt = pre_rise && (cnt == adcs_pkg::NORM_LAST); // [RULE12]
				end
				if (done_evt) begin
					next_first = 1'b0;
					// Done-flag source chains regardless of the flag state
					if (auto_trigger_enable && free_sel && fifo_in_ready) begin
						next_cnt = adcs_pkg::CNT_ZERO; // [RULE7] [RULE16]
						next_auto = 1'b0;
					end else begin
						next_state = adcs_pkg::ADCS_IDLE; // [RULE14] [RULE5]
					end
				end
			end
			default: next_state = adcs_pkg::ADCS_IDLE;
		endcase
		if (!converter_enable || converter_power_reduction) begin
			next_state = adcs_pkg::ADCS_IDLE;
		end
		if (converter_enable && !en_prev) begin
			next_first = 1'b1; // [RULE12]
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= adcs_pkg::ADCS_IDLE;
			cnt <= adcs_pkg::CNT_ZERO;
			first <= 1'b0;
			auto_mode <= 1'b0;
			conversion_start_bit <= 1'b0;
			conv_active <= 1'b0;
			sample_hold <= 1'b0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			first <= next_first;
			auto_mode <= next_auto;
			conversion_start_bit <= (next_state != adcs_pkg::ADCS_IDLE); // [RULE8] [RULE16]
			conv_active <= (next_state == adcs_pkg::ADCS_CONV);
			sample_hold <= next_sh;
		end
	end

	// Selection buffer and active selection
	always_comb begin
		next_chan_buf = selection_write ? channel_select_wdata : chan_buf; // [RULE17]
		next_ref_buf = selection_write ? reference_select_wdata : ref_buf;
		next_chan = channel_select;
		next_ref = reference_select;
		if (converter_enable && copy_en) begin
			next_chan = chan_buf; // [RULE2] [RULE21] [RULE23]
			next_ref = ref_buf;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			chan_buf <= adcs_pkg::CHAN_RESET;
			ref_buf <= adcs_pkg::REF_RESET;
			channel_select <= adcs_pkg::CHAN_RESET;
			reference_select <= adcs_pkg::REF_RESET;
		end else begin
			chan_buf <= next_chan_buf;
			ref_buf <= next_ref_buf;
			channel_select <= next_chan;
			reference_select <= next_ref;
		end
	end

	// Done flag and interrupt; a set beats a same-cycle clear
	always_comb begin
		next_flag = done_evt || (conversion_done_flag && !done_flag_clear); // [RULE6] [RULE26]
		next_irq = conversion_done_flag && done_int_enable; // [RULE26]
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			conversion_done_flag <= 1'b0;
			done_irq <= 1'b0;
		end else begin
			conversion_done_flag <= next_flag;
			done_irq <= next_irq;
		end
	end

	// Results queue; full queue holds off new starts
	adcs_fifo #(
		.WIDTH(adcs_pkg::RES_W),
		.DEPTH(adcs_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rst(rst),
		.in_valid(done_evt && !lock), // [RULE22]
		.in_data(analog_result),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_data)
	);

	assign fifo_out_ready = !lock && !result_low_read;

	// Result register, blocked between low and high reads
	always_comb begin
		next_lock = lock;
		if (result_high_read) begin
			next_lock = 1'b0; // [RULE22]
		end else if (result_low_read) begin
			next_lock = 1'b1;
		end
		next_raw = (fifo_out_valid && fifo_out_ready) ? fifo_data : raw; // [RULE14]
		next_res = fmt_result(raw, left_adjust_result); // [RULE24]
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			lock <= 1'b0;
			raw <= adcs_pkg::RESULT_RESET;
			result_low_byte <= 8'h00;
			result_high_byte <= 8'h00;
		end else begin
			lock <= next_lock;
			raw <= next_raw;
			result_low_byte <= next_res[7:0];
			result_high_byte <= next_res[15:8];
		end
	end

	// Checks
	property p_start_taken; // [RULE1]
		@(posedge core_clk) disable iff (rst)
		(state == adcs_pkg::ADCS_IDLE) && can_start && start_write |=> conversion_start_bit;
	endproperty
	a_start_taken: assert property (p_start_taken) else $error("start write not taken");

	property p_busy_reads_one; // [RULE8]
		@(posedge core_clk) disable iff (rst)
		conv_active |-> conversion_start_bit;
	endproperty
	a_busy_reads_one: assert property (p_busy_reads_one) else $error("start bit low while busy");

	property p_done_sets_flag; // [RULE14]
		@(posedge core_clk) disable iff (rst)
		done_evt |=> conversion_done_flag ##1 (done_irq == $past(done_int_enable));
	endproperty
	a_done_sets_flag: assert property (p_done_sets_flag) else $error("done flag or irq wrong");

	property p_busy_edge_ignored; // [RULE5]
		@(posedge core_clk) disable iff (rst)
		(state == adcs_pkg::ADCS_CONV) && !done_evt && converter_enable
			&& !converter_power_reduction |=> $stable(auto_mode) || (state == adcs_pkg::ADCS_IDLE);
	endproperty
	a_busy_edge_ignored: assert property (p_busy_edge_ignored) else $error("trigger accepted busy");

	property p_normal_length; // [RULE12]
		@(posedge core_clk) disable iff (rst)
		(state == adcs_pkg::ADCS_CONV) && !first && !auto_mode && pre_rise
			&& (cnt == adcs_pkg::NORM_LAST) |-> done_evt;
	endproperty
	a_normal_length: assert property (p_normal_length) else $error("normal conversion length");

	property p_sel_locked; // [RULE17]
		@(posedge core_clk) disable iff (rst)
		!copy_en |=> $stable(channel_select) && $stable(reference_select);
	endproperty
	a_sel_locked: assert property (p_sel_locked) else $error("selection changed while locked");

	property p_prescaler_held; // [RULE9]
		@(posedge core_clk) disable iff (rst)
		!converter_enable |=> !pre_rise && !pre_fall;
	endproperty
	a_prescaler_held: assert property (p_prescaler_held) else $error("prescaler ran disabled");

	property p_result_blocked; // [RULE22]
		@(posedge core_clk) disable iff (rst)
		lock && !result_high_read |=> $stable(raw);
	endproperty
	a_result_blocked: assert property (p_result_blocked) else $error("result changed while blocked");

	property p_disabled_no_copy; // [RULE23]
		@(posedge core_clk) disable iff (rst)
		!converter_enable |=> $stable(channel_select);
	endproperty
	a_disabled_no_copy: assert property (p_disabled_no_copy) else $error("selection copied disabled");
endmodule : adcs_sequencer
`default_nettype wire

// ==== testbench/adcs_analog_model.sv ====
// Behavioural analog core answering the sequencer
`timescale 1ns/10ps
`default_nettype none
module adcs_analog_model (
	// Clock
	input wire logic core_clk,
	// Control from the sequencer
	input wire logic conv_active,
	input wire logic sample_hold,
	input wire logic [3:0] channel_select,
	input wire logic [1:0] reference_select,
	// Result to the sequencer
	output logic [9:0] analog_result
);
	logic [9:0] held = 10'h2AA;
	// Code taken at the sample instant; garbled while no conversion runs
	always_ff @(posedge core_clk) begin
		if (sample_hold) begin
			held <= {channel_select, reference_select, 4'h5};
		end else if (!conv_active) begin
			held <= ~held;
		end
	end
	assign analog_result = held;
endmodule : adcs_analog_model
`default_nettype wire

// ==== testbench/adc_conversion_sequencer_tb_top.sv ====
// Self-checking bench for the conversion sequencer and its result FIFO
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer_tb_top;
	typedef struct {logic [3:0] chan; logic [1:0] rsel; logic ladj; logic [2:0] psel; int ratio;
		bit first;} adcs_row_s;
	localparam logic [4:0] START = 5'h10, CLR = 5'h08, LO = 5'h04, HI = 5'h02, SEL = 5'h01;
	logic core_clk = 1'b0, rst = 1'b1, en = 1'b1, pwr_red = 1'b0, start_wr = 1'b0, auto_en = 1'b0;
	logic ladj = 1'b0, sel_wr = 1'b0, flag_clr = 1'b0, irq_en = 1'b0, lo_rd = 1'b0, hi_rd = 1'b0;
	logic [2:0] tsel = 3'h1, psel = 3'h0;
	logic [3:0] ch_wd = 4'h0;
	logic [1:0] rf_wd = 2'h0;
	logic [6:0] trig = 7'h00;
	logic [9:0] a_res;
	logic start_bit, done_flag, irq, active, sh, act_q = 1'b0, mon = 1'b0;
	logic [7:0] lo, hi;
	logic [3:0] chan_sel;
	logic [1:0] ref_sel;
	int n_errors = 0, checks_done = 0, cyc_now = 0, n_sh = 0, sh_at = 0, n_end = 0, n_low = 0;
	int st, dur;
	adcs_row_s rows [4] = '{'{4'h3, 2'h1, 1'b0, 3'h0, 2, 1}, '{4'hC, 2'h2, 1'b1, 3'h2, 4, 0},
		'{4'h5, 2'h3, 1'b0, 3'h3, 8, 0}, '{4'hF, 2'h0, 1'b1, 3'h1, 2, 0}};

	// Design and analog core
	adcs_sequencer DUT (.core_clk(core_clk), .rst(rst), .converter_enable(en),
		.converter_power_reduction(pwr_red), .start_write(start_wr), .auto_trigger_enable(auto_en),
		.trigger_source_select(tsel), .prescaler_select(psel), .left_adjust_result(ladj),
		.selection_write(sel_wr), .channel_select_wdata(ch_wd), .reference_select_wdata(rf_wd),
		.done_flag_clear(flag_clr), .done_int_enable(irq_en), .result_low_read(lo_rd),
		.result_high_read(hi_rd), .trigger_pins(trig), .analog_result(a_res),
		.conversion_start_bit(start_bit), .conversion_done_flag(done_flag), .done_irq(irq),
		.result_low_byte(lo), .result_high_byte(hi), .conv_active(active), .sample_hold(sh),
		.channel_select(chan_sel), .reference_select(ref_sel));
	adcs_analog_model u_core (.core_clk(core_clk), .conv_active(active), .sample_hold(sh),
		.channel_select(chan_sel), .reference_select(ref_sel), .analog_result(a_res));

	// Clock, 4 ns period
	always #2 core_clk = ~core_clk;

	// Cycle count, sample pulses, conversion ends, timeout
	always @(posedge core_clk) begin
		cyc_now++;
		if (sh === 1'b1) begin
			n_sh++;
			sh_at = cyc_now;
		end
		if (act_q === 1'b1 && active !== 1'b1) n_end++;
		act_q = active;
		if (mon && start_bit !== 1'b1) n_low++;
		if (cyc_now == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : tick

	// One-cycle strobes: start, flag clear, low read, high read, selection write
	// An idle cycle follows, so back-to-back calls never re-drive within one step
	task automatic pulse(input logic [4:0] m);
		{start_wr, flag_clr, lo_rd, hi_rd, sel_wr} = m;
		tick(1);
		{start_wr, flag_clr, lo_rd, hi_rd, sel_wr} = 5'h00;
		tick(1);
	endtask : pulse

	task automatic wait_flag(input int t0, output int d);
		for (int i = 0; i < 3000 && done_flag !== 1'b1; i++) tick(1);
		d = cyc_now - t0;
	endtask : wait_flag

	function automatic logic [15:0] exp_bytes(input logic [3:0] c, input logic [1:0] r,
		input logic la);
		logic [9:0] v;
		v = {c, r, 4'h5};
		exp_bytes = la ? {v, 6'h00} : {6'h00, v};
	endfunction : exp_bytes

	function automatic logic [15:0] in_rng(input int v, input int a, input int b);
		in_rng = {15'h0, v >= a && v <= b};
	endfunction : in_rng

	// Single conversion with selection, timing and result checks
	task automatic do_conv(input adcs_row_s r);
		int base;
		ladj = r.ladj;
		psel = r.psel;
		ch_wd = r.chan;
		rf_wd = r.rsel;
		pulse(SEL);
		tick(2);
		n_sh = 0;
		st = cyc_now;
		pulse(START);
		tick(1);
		check({15'h0, start_bit}, 16'h0001);
		check({10'h0, chan_sel, ref_sel}, {10'h0, r.chan, r.rsel});
		wait_flag(st, dur);
		base = r.first ? 25 : 13;
		check(in_rng(dur, base * r.ratio, (base + 1) * r.ratio + 5), 16'h0001);
		base = r.first ? 13 : 1;
		check(in_rng(sh_at - st, base * r.ratio, (base + 2) * r.ratio + 5), 16'h0001);
		check(16'(n_sh), 16'h0001);
		check({15'h0, start_bit}, 16'h0000);
		tick(3);
		check({hi, lo}, exp_bytes(r.chan, r.rsel, r.ladj));
		pulse(LO);
		pulse(HI);
		pulse(CLR);
	endtask : do_conv

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	// Main sequence
	initial begin
		tick(4);
		rst = 1'b0;
		tick(2);
		check({start_bit, done_flag, irq, active, hi[3:0], lo}, 16'h0000);
		foreach (rows[i]) do_conv(rows[i]);
		// Start refused under power reduction
		pwr_red = 1'b1;
		pulse(START);
		tick(40);
		check({14'h0, start_bit, done_flag}, 16'h0000);
		pwr_red = 1'b0;
		// Channel change mid-conversion, then result lock and interrupt
		ch_wd = 4'h2;
		rf_wd = 2'h1;
		ladj = 1'b0;
		psel = 3'h0;
		pulse(SEL);
		tick(2);
		st = cyc_now;
		pulse(START);
		tick(6);
		ch_wd = 4'h9;
		pulse(SEL);
		tick(3);
		check({12'h0, chan_sel}, 16'h0002);
		wait_flag(st, dur);
		tick(3);
		check({hi, lo}, exp_bytes(4'h2, 2'h1, 1'b0));
		check({12'h0, chan_sel}, 16'h0009);
		pulse(LO);
		pulse(CLR);
		st = cyc_now;
		pulse(START);
		wait_flag(st, dur);
		tick(3);
		check({hi, lo}, exp_bytes(4'h2, 2'h1, 1'b0));
		check({15'h0, done_flag}, 16'h0001);
		irq_en = 1'b1;
		tick(2);
		check({15'h0, irq}, 16'h0001);
		pulse(CLR);
		tick(2);
		check({14'h0, done_flag, irq}, 16'h0000);
		irq_en = 1'b0;
		pulse(HI);
		// Auto trigger on pin 0, with a second edge mid-conversion
		auto_en = 1'b1;
		tsel = 3'h1;
		n_end = 0;
		st = cyc_now;
		trig[0] = 1'b1;
		tick(8);
		check({14'h0, start_bit, active}, 16'h0003);
		trig[0] = 1'b0;
		tick(2);
		trig[0] = 1'b1;
		wait_flag(st, dur);
		check(in_rng(dur, 29, 36), 16'h0001);
		check(in_rng(sh_at - st, 6, 11), 16'h0001);
		tick(80);
		check(16'(n_end), 16'h0001);
		pulse(CLR);
		n_end = 0;
		st = cyc_now;
		pulse(START);
		wait_flag(st, dur);
		tick(2);
		check(16'(n_end), 16'h0001);
		pulse(CLR);
		trig[0] = 1'b0;
		// Free running on completion, flag left set
		tsel = 3'h0;
		pulse(START);
		tick(2);
		n_sh = 0;
		mon = 1'b1;
		tick(120);
		mon = 1'b0;
		check(16'(n_low), 16'h0000);
		check(in_rng(n_sh, 3, 5), 16'h0001);
		auto_en = 1'b0;
		for (int i = 0; i < 200 && start_bit !== 1'b0; i++) tick(1);
		check({15'h0, start_bit}, 16'h0000);
		pulse(CLR);
		pulse(LO);
		pulse(HI);
		// Enable cycled: prescaler reset and a first conversion again
		en = 1'b0;
		tick(5);
		en = 1'b1;
		tick(1);
		do_conv(adcs_row_s'{4'h7, 2'h2, 1'b0, 3'h0, 2, 1});
		// Result queue through the top: a locked completion is dropped, the next lands
		pulse(LO);
		ch_wd = 4'hA;
		rf_wd = 2'h3;
		pulse(SEL);
		tick(2);
		st = cyc_now;
		pulse(START);
		wait_flag(st, dur);
		pulse(HI);
		tick(3);
		check({hi, lo}, exp_bytes(4'h7, 2'h2, 1'b0));
		pulse(CLR);
		st = cyc_now;
		pulse(START);
		wait_flag(st, dur);
		tick(3);
		check({hi, lo}, exp_bytes(4'hA, 2'h3, 1'b0));
		check(in_rng(dur, 13 * 2, 14 * 2 + 5), 16'h0001);
		wrap_up();
	end
endmodule : adc_conversion_sequencer_tb_top
`default_nettype wire
